// File: verilog/ibs_status.sv
// Bus status flag logic of a two-wire serial bus interface, with APB registers.
// Assumes the rest of the unit (shifter, master sequencer, address match)
// runs on clk_sys and hands in its events as one-cycle pulses.
module ibs_status (
	// Clock, reset, clock enable
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	input  wire logic                  ce,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Two-wire bus pins
	input  wire logic                  serial_clock_line,
	input  wire logic                  serial_data_line,
	output logic                       sda_drv,
	output logic                       sda_oe,
	// Rest of the unit, same clock
	input  wire logic                  master_mode,
	input  wire logic                  start_gen,
	input  wire logic                  dir_bit_out,
	input  wire logic                  dir_bit_val,
	input  wire logic                  not_addressed,
	input  wire logic                  wait_ninth,
	input  wire logic                  so_latch,
	input  wire logic                  arb_lost_flag,
	// Status and triggers to the unit
	output ibs_pkg::ibs_flags_type     bus_flags,
	output logic                       port_enable_bit,
	output logic                       comm_exit_trigger,
	output logic                       wait_release_trigger,
	// Interrupt
	output logic                       irq
);

	logic                   rst_m_q;
	logic                   rst_n_q;
	logic                   scl_m_q, scl_s_q, scl_p_q;
	logic                   sda_m_q, sda_s_q, sda_p_q;
	logic                   arb_p_q;
	logic [3:0]             cnt_q;
	logic [3:0]             cnt_d;
	logic                   first_q;
	logic                   first_d;
	logic                   drive_ok_q;
	logic                   drive_ok_d;
	ibs_pkg::ibs_flags_type flags_q;
	ibs_pkg::ibs_flags_type flags_d;
	logic                   en_q;
	logic                   en_d;
	logic [2:0]             irq_stat_q;
	logic [2:0]             irq_stat_d;
	logic [2:0]             irq_mask_q;
	logic [31:0]            prdata_q;
	logic                   pready_q;
	logic                   pslverr_q;
	logic                   sda_oe_q;
	logic                   sda_drv_q;
	logic                   exit_q;
	logic                   wrel_q;
	logic                   irq_q;
	logic                   dir_set, dir_clr, dir_hard;
	logic                   ack_set, ack_clr;
	logic                   std_set, std_clr;
	logic                   spd_set, spd_clr;
	ibs_pkg::ibs_apb_req_type req;

	// Reset release through two flops
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// Bus request and decode
	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	wire hit_status = req.paddr == ibs_pkg::STATUS_OFS;
	wire hit_ctrl   = req.paddr == ibs_pkg::CTRL_OFS;
	wire hit_istat  = req.paddr == ibs_pkg::IRQ_STAT_OFS;
	wire hit_imask  = req.paddr == ibs_pkg::IRQ_MASK_OFS;
	wire addr_ok    = hit_status | hit_ctrl | hit_istat | hit_imask;
	wire acc_first  = req.psel & req.penable & ~pready_q;
	wire acc_done   = req.psel & req.penable & pready_q;
	wire wr_done    = acc_done & req.pwrite;
	wire rd_done    = acc_done & ~req.pwrite;

	// Status register has no write path
	wire wr_ctrl    = wr_done & hit_ctrl;
	wire wr_imask   = wr_done & hit_imask;
	wire rd_istat   = rd_done & hit_istat;

	wire [31:0] rd_mux =
		hit_status ? {28'h0000000, flags_q} :
		hit_ctrl   ? {31'h00000000, en_q} :
		hit_istat  ? {29'h00000000, irq_stat_q} :
		hit_imask  ? {29'h00000000, irq_mask_q} : 32'h00000000;

	// Enable and software triggers
	assign en_d       = wr_ctrl ? req.pwdata[ibs_pkg::CTRL_EN_BIT] : en_q;
	wire   en_fall    = en_q & ~en_d;
	wire   exit_req   = wr_ctrl & req.pwdata[ibs_pkg::CTRL_EXIT_BIT] & en_d;
	wire   wrel_req   = wr_ctrl & req.pwdata[ibs_pkg::CTRL_WREL_BIT] & en_d;

	// Bus events from the synchronised pins, never from the first flops; arbitration loss from the unit's flag
	wire scl_rise  = scl_s_q & ~scl_p_q;
	wire scl_fall  = ~scl_s_q & scl_p_q;
	wire start_evt = en_q & scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	wire stop_evt  = en_q & scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	wire arb_rise  = arb_lost_flag & ~arb_p_q;

	wire rise_ninth  = en_q & scl_rise & (cnt_q == ibs_pkg::CNT_ACK_BIT);
	wire rise_next   = en_q & scl_rise & (cnt_q == ibs_pkg::CNT_NINTH);
	wire fall_ninth  = en_q & scl_fall & (cnt_q == ibs_pkg::CNT_NINTH) & first_q;
	wire slave_read  = en_q & scl_rise & (cnt_q == ibs_pkg::CNT_DIR_BIT) & first_q
		& ~master_mode & sda_s_q;

	// Clock counter within a byte; counts from the start condition
	assign cnt_d =
		(start_evt | stop_evt | ~en_d) ? ibs_pkg::CNT_IDLE :
		rise_next                      ? ibs_pkg::CNT_FIRST :
		(en_q & scl_rise)              ? 4'(cnt_q + 4'h1) : cnt_q;
	assign first_d =
		start_evt          ? 1'b1 :
		(stop_evt | ~en_d) ? 1'b0 :
		rise_next          ? 1'b0 : first_q;

	// Output stage is held off until the first byte's ninth clock falls
	assign drive_ok_d =
		(start_evt | stop_evt | ~en_d)   ? 1'b0 :
		(wrel_req & flags_q.direction_flag & wait_ninth) ? 1'b0 :
		fall_ninth                       ? 1'b1 : drive_ok_q;

	// Direction flag terms
	assign dir_set = en_q & ((master_mode & start_gen)
		| (master_mode & dir_bit_out & ~dir_bit_val)
		| slave_read);
	assign dir_clr = exit_req | wrel_req
		| (en_q & master_mode & dir_bit_out & dir_bit_val)
		| (en_q & ~master_mode & (start_evt | not_addressed));
	assign dir_hard = stop_evt | arb_rise | ~en_d;

	// Clears in dir_clr lose to a set in the same cycle; stop, arbitration loss and disable win
	assign flags_d.direction_flag =
		dir_hard ? 1'b0 :
		dir_set  ? 1'b1 :
		dir_clr  ? 1'b0 : flags_q.direction_flag;

	assign ack_set = rise_ninth & ~sda_s_q;
	assign ack_clr = rise_next | exit_req;
	assign flags_d.ack_seen_flag =
		(stop_evt | ~en_d) ? 1'b0 :
		ack_set            ? 1'b1 :
		ack_clr            ? 1'b0 : flags_q.ack_seen_flag;

	assign std_set = start_evt;
	assign std_clr = (rise_next & first_q) | exit_req;
	assign flags_d.start_seen_flag =
		(stop_evt | ~en_d) ? 1'b0 :
		std_set            ? 1'b1 :
		std_clr            ? 1'b0 : flags_q.start_seen_flag;

	assign spd_set = stop_evt;
	assign spd_clr = en_q & scl_rise & flags_q.start_seen_flag;
	assign flags_d.stop_seen_flag =
		~en_d   ? 1'b0 :
		spd_set ? 1'b1 :
		spd_clr ? 1'b0 : flags_q.stop_seen_flag;

	// Open drain: enable only to pull low; direction 0 keeps it released
	wire oe_d = flags_d.direction_flag & drive_ok_d & ~so_latch;

	// Sticky events; a read clears only the bits it returned
	wire [2:0] irq_evt = {ack_set, std_set, spd_set};
	wire [2:0] irq_clr = rd_istat ? prdata_q[2:0] : 3'h0;
	assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;

	// Pin synchronisers
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
			arb_p_q <= 1'b0;
		end else if (ce) begin
			scl_m_q <= serial_clock_line;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= serial_data_line;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
			arb_p_q <= arb_lost_flag;
		end
	end

	// Flags and sequencing state
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			flags_q    <= ibs_pkg::FLAGS_RESET;
			cnt_q      <= ibs_pkg::CNT_IDLE;
			first_q    <= 1'b0;
			drive_ok_q <= 1'b0;
			sda_oe_q   <= 1'b0;
			sda_drv_q  <= 1'b0;
		end else if (ce) begin
			flags_q    <= flags_d;
			cnt_q      <= cnt_d;
			first_q    <= first_d;
			drive_ok_q <= drive_ok_d;
			sda_oe_q   <= oe_d;
			sda_drv_q  <= so_latch;
		end
	end

	// Registers and bus answer; one wait state so read data comes from a flop
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			en_q       <= 1'b0;
			exit_q     <= 1'b0;
			wrel_q     <= 1'b0;
			irq_stat_q <= ibs_pkg::IRQ_RESET;
			irq_mask_q <= ibs_pkg::IRQ_RESET;
			irq_q      <= 1'b0;
			prdata_q   <= 32'h00000000;
			pready_q   <= 1'b0;
			pslverr_q  <= 1'b0;
		end else if (ce) begin
			en_q       <= en_d;
			exit_q     <= exit_req;
			wrel_q     <= wrel_req;
			irq_stat_q <= irq_stat_d;
			if (wr_imask) begin
				irq_mask_q <= req.pwdata[2:0];
			end
			irq_q      <= |(irq_stat_d & (wr_imask ? req.pwdata[2:0] : irq_mask_q));
			pready_q   <= acc_first;
			if (acc_first) begin
				prdata_q  <= req.pwrite ? 32'h00000000 : rd_mux;
				pslverr_q <= ~addr_ok | (req.pwrite & hit_status);
			end
		end
	end

	assign prdata               = prdata_q;
	assign pready               = pready_q;
	assign pslverr              = pslverr_q;
	assign sda_drv              = sda_drv_q;
	assign sda_oe               = sda_oe_q;
	assign bus_flags            = flags_q;
	assign port_enable_bit      = en_q;
	assign comm_exit_trigger    = exit_q;
	assign wait_release_trigger = wrel_q;
	assign irq                  = irq_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n_q);

	a_rx_release: assert property (!flags_q.direction_flag |-> !sda_oe_q)
		else $error("data line driven while receiving");
	a_tx_drive: assert property (ce && sda_oe_q |-> drive_ok_q && flags_q.direction_flag)
		else $error("data line driven before first ninth clock fell");
	a_dir_stop: assert property (ce && (stop_evt || arb_rise) |=> !flags_q.direction_flag)
		else $error("direction flag survived stop or arbitration loss");
	a_dir_master: assert property (ce && en_q && !en_fall && !stop_evt && !arb_rise
		&& master_mode && start_gen |=> flags_q.direction_flag)
		else $error("direction flag not set on generated start");
	a_wrel_release: assert property (ce && wrel_req && wait_ninth
		&& flags_q.direction_flag |=> !drive_ok_q ##1 !sda_oe_q [*2])
		else $error("data line not released on wait release");
	a_ack_set: assert property (ce && rise_ninth && !sda_s_q && !stop_evt && !en_fall
		|=> flags_q.ack_seen_flag)
		else $error("ack flag not set on low ninth clock");
	a_ack_clear: assert property (ce && rise_next |=> !flags_q.ack_seen_flag)
		else $error("ack flag not cleared at next byte");
	a_start_flag: assert property (ce && start_evt && !en_fall
		|=> flags_q.start_seen_flag && cnt_q == ibs_pkg::CNT_IDLE)
		else $error("start flag not set on start condition");
	a_start_clear: assert property (ce && stop_evt |=> !flags_q.start_seen_flag)
		else $error("start flag survived stop condition");
	a_stop_flag: assert property (ce && stop_evt && !en_fall |=> flags_q.stop_seen_flag)
		else $error("stop flag not set on stop condition");
	a_disable_clear: assert property (ce && en_fall
		|=> flags_q == ibs_pkg::FLAGS_RESET && !en_q)
		else $error("flags not cleared when port disabled");
	a_status_ro: assert property (ce && acc_first && req.pwrite && hit_status
		|=> pready_q && pslverr_q)
		else $error("status write not refused");

	// Clears and sets; a term that wins over the checked one in the same cycle is left out
	a_dir_sw_clear: assert property (ce && (exit_req || wrel_req) && !dir_set
		|=> !flags_q.direction_flag)
		else $error("direction flag survived exit or wait release");
	a_master_dir_clear: assert property (ce && en_q && master_mode && dir_bit_out
		&& dir_bit_val && !dir_set |=> !flags_q.direction_flag)
		else $error("direction flag not cleared by read request");
	a_slave_dir_set: assert property (ce && slave_read && !dir_hard
		|=> flags_q.direction_flag)
		else $error("direction flag not set by read bit");
	a_slave_dir_clear: assert property (ce && en_q && !master_mode
		&& (start_evt || not_addressed) && !dir_set |=> !flags_q.direction_flag)
		else $error("slave direction flag not cleared");
	a_ack_sw_clear: assert property (ce && (exit_req || stop_evt) && !ack_set
		|=> !flags_q.ack_seen_flag)
		else $error("ack flag survived exit or stop");
	a_start_byte_clear: assert property (ce && ((rise_next && first_q) || exit_req)
		&& !start_evt |=> !flags_q.start_seen_flag)
		else $error("start flag not cleared after address byte");
	a_stop_later: assert property (ce && spd_clr && !stop_evt
		|=> !flags_q.stop_seen_flag)
		else $error("stop flag not cleared after later start");
	a_disabled_idle: assert property (ce && !en_d
		|=> flags_q == ibs_pkg::FLAGS_RESET && !drive_ok_q)
		else $error("flags or driver active while disabled");
	a_drive_cut: assert property (ce && (start_evt || stop_evt)
		|=> !drive_ok_q && !sda_oe_q)
		else $error("data line still driven after start or stop");
	a_drive_open: assert property (ce && fall_ninth && en_d && !wrel_req
		|=> drive_ok_q)
		else $error("driver not allowed after first ninth clock fell");

endmodule : ibs_status

// File: verilog/ibs_pkg.sv
// Constants, register map and carrier types of the bus status flag block.
// Assumes an APB master with 32-bit data and an 8-bit byte address.
package ibs_pkg;

	// Register byte offsets
	localparam logic [7:0] STATUS_OFS   = 8'h00;
	localparam logic [7:0] CTRL_OFS     = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

	// Control register bit positions
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_EXIT_BIT = 1;
	localparam int CTRL_WREL_BIT = 2;

	// Interrupt status bit positions
	localparam int IRQ_STOP_BIT  = 0;
	localparam int IRQ_START_BIT = 1;
	localparam int IRQ_ACK_BIT   = 2;

	// Serial clock counts within a byte
	localparam logic [3:0] CNT_IDLE    = 4'h0;
	localparam logic [3:0] CNT_FIRST   = 4'h1;
	localparam logic [3:0] CNT_DIR_BIT = 4'h7;
	localparam logic [3:0] CNT_ACK_BIT = 4'h8;
	localparam logic [3:0] CNT_NINTH   = 4'h9;

	// Values after reset
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [2:0] IRQ_RESET   = 3'h0;

	typedef struct packed {
		logic direction_flag;
		logic ack_seen_flag;
		logic start_seen_flag;
		logic stop_seen_flag;
	} ibs_flags_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} ibs_apb_req_type;

endpackage : ibs_pkg

// File: tb/ibs_bus_partner.sv
// Behavioural far-side bus master: start, one byte with acknowledge, stop.
// Assumes an open-drain wire with a pull-up; serial clock period 125 ns.
module ibs_bus_partner (
	// Open-drain outputs, 1 = released
	output logic scl,
	output logic sda_o
);
	timeunit 1ns;
	timeprecision 10ps;

	// Clock parked high between frames, as on an idle bus
	initial begin
		scl = 1'b1;
		sda_o = 1'b1;
	end

	task automatic do_start;
		sda_o = 1'b0;
		#62.5 scl = 1'b0;
	endtask : do_start

	// Data only changes while the clock is low
	task automatic do_byte(input logic [7:0] b, input logic ack_low);
		logic [8:0] sh;
		sh = {b, !ack_low};
		for (int i = 0; i < 9; i++) begin
			#31.25 sda_o = sh[8];
			sh = sh << 1;
			#31.25 scl = 1'b1;
			#62.5 scl = 1'b0;
		end
		#31.25 sda_o = 1'b1;
	endtask : do_byte

	task automatic do_stop;
		#31.25 sda_o = 1'b0;
		#31.25 scl = 1'b1;
		#62.5 sda_o = 1'b1;
		#62.5;
	endtask : do_stop
endmodule : ibs_bus_partner

// File: tb/ibs_status_tb.sv
// Self-checking bench of the bus status flags: APB master, unit pulses, bus partner.
// Assumes ibs_pkg and ibs_status compiled first; the data wire is wired-AND.
module ibs_status_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic                  clk_sys, rstn, ce, psel, penable, pwrite, pready, pslverr, irq;
	logic                  master_mode, start_gen, dir_bit_out, dir_bit_val, not_addressed;
	logic                  wait_ninth, so_latch, arb_lost_flag, sda_drv, sda_oe, p_scl, p_sda;
	logic                  port_enable_bit, comm_exit_trigger, wait_release_trigger;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata, rng;
	ibs_pkg::ibs_flags_type bus_flags;
	wire                   serial_clock_line = p_scl;
	wire                   serial_data_line = p_sda & ~sda_oe;
	int                    mismatches, n_compared;

	ibs_status ibs_status_inst (.clk_sys, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .serial_clock_line, .serial_data_line, .sda_drv, .sda_oe,
		.master_mode, .start_gen, .dir_bit_out, .dir_bit_val, .not_addressed, .wait_ninth,
		.so_latch, .arb_lost_flag, .bus_flags, .port_enable_bit, .comm_exit_trigger,
		.wait_release_trigger, .irq);
	ibs_bus_partner ibs_bus_partner_inst (.scl(p_scl), .sda_o(p_sda));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	// Flags after a slave address byte: direction is the last bit
	function automatic logic [3:0] slave_flags(input logic [7:0] b, input logic ack_low);
		return {b[0], ack_low, 2'b10};
	endfunction : slave_flags

	task automatic give_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Holds the request until pready is seen high at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] ed, input logic ee);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		check({31'h0, pslverr}, {31'h0, ee});
		if (!w) begin
			check(prdata, ed);
		end
	endtask : xfer

	// Bus events need the synchroniser delay before flags settle
	task automatic fl(input logic [3:0] e);
		repeat (6) @(posedge clk_sys);
		check({28'h0, bus_flags}, {28'h0, e});
	endtask : fl

	task automatic dchk(input logic e);
		repeat (3) @(posedge clk_sys);
		check({31'h0, bus_flags.direction_flag}, {31'h0, e});
	endtask : dchk

	task automatic pulse(input int k, input logic v);
		@(posedge clk_sys);
		start_gen <= (k == 0);
		dir_bit_out <= (k == 1);
		dir_bit_val <= v;
		not_addressed <= (k == 2);
		@(posedge clk_sys);
		{start_gen, dir_bit_out, not_addressed} <= 3'h0;
	endtask : pulse

	initial begin
		repeat (60000) @(posedge clk_sys);
		mismatches++;
		give_verdict();
	end

	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata, master_mode, start_gen} = '0;
		{dir_bit_out, dir_bit_val, not_addressed, wait_ninth, arb_lost_flag} = '0;
		ce = 1'b1;
		so_latch = 1'b0;
		rng = 32'd98205;
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check({28'h0, bus_flags}, 32'h0);
		xfer(1'b0, ibs_pkg::STATUS_OFS, 32'h0, 32'h0, 1'b0);
		xfer(1'b1, ibs_pkg::STATUS_OFS, 32'hf, 32'h0, 1'b1);
		xfer(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
		xfer(1'b1, ibs_pkg::CTRL_OFS, 32'h1, 32'h0, 1'b0);
		xfer(1'b0, ibs_pkg::CTRL_OFS, 32'h0, 32'h1, 1'b0);
		xfer(1'b1, ibs_pkg::IRQ_MASK_OFS, 32'h7, 32'h0, 1'b0);
		xfer(1'b0, ibs_pkg::IRQ_MASK_OFS, 32'h0, 32'h7, 1'b0);
		ibs_bus_partner_inst.do_start();
		ibs_bus_partner_inst.do_byte(8'ha1, 1'b1);
		fl(4'b1110);
		check({30'h0, sda_oe, sda_drv}, 32'h2);
		check({31'h0, irq}, 32'h1);
		xfer(1'b0, ibs_pkg::IRQ_STAT_OFS, 32'h0, 32'h6, 1'b0);
		repeat (2) @(posedge clk_sys);
		check({31'h0, irq}, 32'h0);
		wait_ninth <= 1'b1;
		xfer(1'b1, ibs_pkg::CTRL_OFS, 32'h5, 32'h0, 1'b0);
		@(posedge clk_sys);
		check({29'h0, port_enable_bit, comm_exit_trigger, wait_release_trigger}, 32'h5);
		@(posedge clk_sys);
		check({31'h0, wait_release_trigger}, 32'h0);
		dchk(1'b0);
		check({31'h0, sda_oe}, 32'h0);
		wait_ninth <= 1'b0;
		ibs_bus_partner_inst.do_byte(8'h5a, 1'b0);
		fl(4'b0000);
		ibs_bus_partner_inst.do_stop();
		fl(4'b0001);
		check({31'h0, irq}, 32'h1);
		xfer(1'b1, ibs_pkg::IRQ_MASK_OFS, 32'h0, 32'h0, 1'b0);
		repeat (2) @(posedge clk_sys);
		check({31'h0, irq}, 32'h0);
		xfer(1'b0, ibs_pkg::IRQ_STAT_OFS, 32'h0, 32'h1, 1'b0);
		so_latch <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rng = xs(rng);
			ibs_bus_partner_inst.do_start();
			ibs_bus_partner_inst.do_byte(rng[7:0], rng[8]);
			fl(slave_flags(rng[7:0], rng[8]));
			check({30'h0, sda_oe, sda_drv}, 32'h1);
			ibs_bus_partner_inst.do_stop();
			fl(4'b0001);
		end
		master_mode <= 1'b1;
		pulse(0, 1'b0);
		dchk(1'b1);
		pulse(1, 1'b1);
		dchk(1'b0);
		pulse(1, 1'b0);
		dchk(1'b1);
		arb_lost_flag <= 1'b1;
		dchk(1'b0);
		arb_lost_flag <= 1'b0;
		// Clock enable low: a start pulse must leave the flag alone
		ce <= 1'b0;
		pulse(0, 1'b0);
		dchk(1'b0);
		ce <= 1'b1;
		pulse(0, 1'b0);
		xfer(1'b1, ibs_pkg::CTRL_OFS, 32'h3, 32'h0, 1'b0);
		@(posedge clk_sys);
		check({29'h0, port_enable_bit, comm_exit_trigger, wait_release_trigger}, 32'h6);
		dchk(1'b0);
		pulse(0, 1'b0);
		master_mode <= 1'b0;
		pulse(2, 1'b0);
		dchk(1'b0);
		master_mode <= 1'b1;
		pulse(0, 1'b0);
		xfer(1'b1, ibs_pkg::CTRL_OFS, 32'h0, 32'h0, 1'b0);
		fl(4'b0000);
		check({29'h0, port_enable_bit, comm_exit_trigger, wait_release_trigger}, 32'h0);
		ibs_bus_partner_inst.do_start();
		ibs_bus_partner_inst.do_byte(8'h01, 1'b1);
		fl(4'b0000);
		give_verdict();
	end
endmodule : ibs_status_tb
